// ---- hdl/osg_map.vh ----
`ifndef OSG_MAP_VH
`define OSG_MAP_VH
`define OSG_SYNC_CTRL_ADDR     8'h10
`define OSG_SYNC_CTRL_RESET    8'h00
`define OSG_PFS_MSB            3
`define OSG_PFS_LSB            0
`define OSG_MODE_STANDALONE    4'h0
`define OSG_MODE_EXT_CLK       4'h1
`define OSG_MODE_SLAVE         4'h2
`define OSG_MODE_SLAVE_EXT_CLK 4'h3
`define OSG_MODE_MASTER        4'h4
`define OSG_INT_OSC_HZ         32768
`define OSG_CLK_HZ             100000000
`define OSG_INT_TICK_DIV       (`OSG_CLK_HZ / `OSG_INT_OSC_HZ)
`define OSG_SLOT_NONE          4'h0
`define OSG_SLOT_ONE           4'h1
`define OSG_SLOT_THREE         4'h3
`define OSG_SLOT_AMBIENT       4'h9
`define OSG_SLOT_A             4'ha
`define OSG_SLOT_C             4'hc
`define OSG_EXPOSE_TICKS       8'h04
`define OSG_TAG_MSB            23
`define OSG_TAG_LSB            19
`define OSG_DATA_MSB           18
`endif

// ---- hdl/osg_seq_mem.v ----
`timescale 1ns/10ps
module osg_seq_mem (
	input  wire       clk_in,
	input  wire       we_in,
	input  wire [2:0] waddr_in,
	input  wire [3:0] wdata_in,
	input  wire [2:0] raddr_in,
	output reg  [3:0] rdata_out
);
	reg [3:0] mem_reg [0:5];
	always @(posedge clk_in) begin
		if (we_in && waddr_in < 3'd6) begin
			mem_reg[waddr_in] <= wdata_in;
		end
		rdata_out <= (raddr_in < 3'd6) ? mem_reg[raddr_in] : 4'h0;
	end
endmodule

// ---- hdl/osg_sync_gpio.v ----
`timescale 1ns/10ps
`include "osg_map.vh"
module osg_sync_gpio (
	input  wire        clk_in,
	input  wire        resetn_in,
	input  wire        reg_we_in,
	input  wire [7:0]  reg_addr_in,
	input  wire [7:0]  reg_wdata_in,
	output reg  [7:0]  reg_rdata_out,
	input  wire        slot_we_in,
	input  wire [2:0]  slot_addr_in,
	input  wire [3:0]  slot_code_in,
	input  wire        sample_period_in,
	input  wire [18:0] adc_value_in,
	input  wire        aux_pin_one_in,
	output reg         aux_pin_one_out,
	output reg         aux_pin_one_oe_out,
	input  wire        aux_pin_two_in,
	output reg         aux_pin_two_out,
	output reg         aux_pin_two_oe_out,
	output reg         emitter_mux_hi_out,
	output reg         fifo_push_out,
	output reg  [23:0] fifo_word_out,
	output wire        busy_out
);
	localparam ST_IDLE   = 4'b0001;
	localparam ST_FETCH  = 4'b0010;
	localparam ST_EXPOSE = 4'b0100;
	localparam ST_PUSH   = 4'b1000;

	// Ratio truncates; cut to the counter width on purpose
	localparam [31:0] INT_TICK_LAST = `OSG_INT_TICK_DIV - 1;

	function is_mux_slot;
		input [3:0] code;
		begin
			is_mux_slot = (code >= `OSG_SLOT_A) && (code <= `OSG_SLOT_C);
		end
	endfunction

	function is_ext_clk_mode;
		input [3:0] m;
		begin
			is_ext_clk_mode = (m == `OSG_MODE_EXT_CLK) || (m == `OSG_MODE_SLAVE_EXT_CLK);
		end
	endfunction

	function is_slave_mode;
		input [3:0] m;
		begin
			is_slave_mode = (m == `OSG_MODE_SLAVE) || (m == `OSG_MODE_SLAVE_EXT_CLK);
		end
	endfunction

	reg [7:0]  ctrl_reg;
	reg [5:0]  mux_slot_map_reg;
	reg [2:0]  pin_sync_reg [0:1];
	reg [2:0]  slot_rd_addr;
	wire [1:0] pin_raw;
	reg [15:0] osc_cnt_reg;
	reg [3:0]  state_reg;
	reg [3:0]  state_next;
	reg [2:0]  slot_idx_reg;
	reg [4:0]  tag_reg;
	reg [7:0]  expose_cnt_reg;
	reg        mux_active_reg;
	reg        pending_reg;
	reg        master_pulse_reg;
	wire [3:0] slot_code;
	wire [3:0] mode;
	wire       int_tick;
	wire       ext_tick;
	wire       time_tick;
	wire       trigger;
	wire       any_mux;
	wire       start;

	assign mode = ctrl_reg[`OSG_PFS_MSB:`OSG_PFS_LSB];
	assign any_mux = |mux_slot_map_reg;

	osg_seq_mem u_mem (
		.clk_in    (clk_in),
		.we_in     (slot_we_in),
		.waddr_in  (slot_addr_in),
		.wdata_in  (slot_code_in),
		.raddr_in  (slot_rd_addr),
		.rdata_out (slot_code)
	);

	// Register port; only the function field is active
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			ctrl_reg <= `OSG_SYNC_CTRL_RESET;
		end else if (reg_we_in && reg_addr_in == `OSG_SYNC_CTRL_ADDR) begin
			ctrl_reg <= reg_wdata_in;
		end
	end

	always @(posedge clk_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= 8'h00;
		end else begin
			reg_rdata_out <= (reg_addr_in == `OSG_SYNC_CTRL_ADDR) ? ctrl_reg : 8'h00;
		end
	end

	// Tracks which slots hold A-C so needs no memory scan
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			mux_slot_map_reg <= 6'h00;
		end else if (slot_we_in && slot_addr_in < 3'd6) begin
			mux_slot_map_reg[slot_addr_in] <= is_mux_slot(slot_code_in);
		end
	end

	// Memory output is registered, so address the slot the next fetch needs
	always @* begin
		slot_rd_addr = slot_idx_reg;
		if (state_reg == ST_IDLE) begin
			slot_rd_addr = 3'd0;
		end else if (state_reg == ST_PUSH) begin
			slot_rd_addr = slot_idx_reg + 3'd1;
		end
	end

	// Pins are asynchronous; third stage only for edge detect
	assign pin_raw = {aux_pin_two_in, aux_pin_one_in};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin_sync
			always @(posedge clk_in) begin
				if (!resetn_in) begin
					pin_sync_reg[gi] <= 3'b000;
				end else begin
					pin_sync_reg[gi] <= {pin_sync_reg[gi][1:0], pin_raw[gi]};
				end
			end
		end
	endgenerate

	// Internal 32768 Hz tick; ratio truncates, small drift accepted
	always @(posedge clk_in) begin
		if (!resetn_in || int_tick) begin
			osc_cnt_reg <= 16'h0000;
		end else begin
			osc_cnt_reg <= osc_cnt_reg + 16'h0001;
		end
	end
	assign int_tick = (osc_cnt_reg == INT_TICK_LAST[15:0]);

	assign ext_tick = pin_sync_reg[1][1] & ~pin_sync_reg[1][2];
	assign time_tick = is_ext_clk_mode(mode) ? ext_tick : int_tick;
	assign trigger = pin_sync_reg[0][1] & ~pin_sync_reg[0][2];

	// Slave modes start only on a trigger; others on the sample period
	assign start = is_slave_mode(mode) ? trigger : sample_period_in;

	// A start during a running sequence is held for exactly one rerun
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			pending_reg <= 1'b0;
		end else if (start && state_reg != ST_IDLE) begin
			pending_reg <= 1'b1;
		end else if (state_reg == ST_IDLE) begin
			pending_reg <= 1'b0;
		end
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start || pending_reg) begin
					state_next = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (slot_code == `OSG_SLOT_NONE || slot_idx_reg == 3'd6) begin
					state_next = ST_IDLE;
				end else begin
					state_next = ST_EXPOSE;
				end
			end
			ST_EXPOSE: begin
				if (time_tick && expose_cnt_reg == `OSG_EXPOSE_TICKS) begin
					state_next = ST_PUSH;
				end
			end
			ST_PUSH: begin
				state_next = ST_FETCH;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Slots run in order, one entry each, so follow from the table
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			state_reg      <= ST_IDLE;
			slot_idx_reg   <= 3'd0;
			tag_reg        <= 5'h00;
			expose_cnt_reg <= 8'h00;
			mux_active_reg <= 1'b0;
			fifo_push_out  <= 1'b0;
			fifo_word_out  <= 24'h000000;
		end else begin
			state_reg     <= state_next;
			fifo_push_out <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					slot_idx_reg <= 3'd0;
					tag_reg      <= 5'h00;
				end
				ST_FETCH: begin
					expose_cnt_reg <= 8'h00;
					mux_active_reg <= is_mux_slot(slot_code);
				end
				ST_EXPOSE: begin
					if (time_tick) begin
						expose_cnt_reg <= expose_cnt_reg + 8'h01;
					end
				end
				ST_PUSH: begin
					mux_active_reg <= 1'b0;
					fifo_push_out  <= 1'b1;
					fifo_word_out  <= {tag_reg + 5'h01, adc_value_in};
					tag_reg        <= tag_reg + 5'h01;
					slot_idx_reg   <= slot_idx_reg + 3'd1;
				end
				default: begin
					mux_active_reg <= 1'b0;
				end
			endcase
		end
	end
	assign busy_out = (state_reg != ST_IDLE);

	// Master strobe at sequence start for a slave device
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			master_pulse_reg <= 1'b0;
		end else begin
			master_pulse_reg <= (state_reg == ST_IDLE) && (state_next == ST_FETCH);
		end
	end

	// Pin roles per mode
	always @* begin
		aux_pin_one_out    = 1'b0;
		aux_pin_one_oe_out = 1'b0;
		aux_pin_two_out    = 1'b0;
		aux_pin_two_oe_out = 1'b0;
		emitter_mux_hi_out = mux_active_reg;
		case (mode)
			`OSG_MODE_STANDALONE, `OSG_MODE_EXT_CLK: begin
				aux_pin_one_out    = mux_active_reg;
				aux_pin_one_oe_out = any_mux;
			end
			`OSG_MODE_SLAVE, `OSG_MODE_MASTER: begin
				aux_pin_two_out    = mux_active_reg;
				aux_pin_two_oe_out = any_mux;
				if (mode == `OSG_MODE_MASTER) begin
					aux_pin_one_out    = master_pulse_reg;
					aux_pin_one_oe_out = 1'b1;
				end
			end
			default: begin
				aux_pin_one_oe_out = 1'b0;
			end
		endcase
	end
endmodule

// ---- tb/osg_sync_gpio_chk.sv ----
`timescale 1ns/10ps
module osg_sync_gpio_chk (
	input wire        clk_in,
	input wire        resetn_in,
	input wire        reg_we_in,
	input wire [7:0]  reg_addr_in,
	input wire [7:0]  reg_wdata_in,
	input wire [7:0]  reg_rdata_out,
	input wire        aux_pin_one_out,
	input wire        aux_pin_one_oe_out,
	input wire        aux_pin_two_oe_out,
	input wire        emitter_mux_hi_out,
	input wire        fifo_push_out,
	input wire [23:0] fifo_word_out
);
	reg [3:0] m_reg;
	always @(posedge clk_in)
		if (!resetn_in)
			m_reg <= 4'h0;
		else if (reg_we_in && reg_addr_in == 8'h10)
			m_reg <= reg_wdata_in[3:0];
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	a_ctrl_readback: assert property (
		reg_we_in && reg_addr_in == 8'h10 ##1 !reg_we_in && reg_addr_in == 8'h10
		|=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("readback wrong");
	a_unmapped_zero: assert property (
		reg_addr_in != 8'h10 |=> reg_rdata_out == 8'h00) else $error("unmapped read");
	a_mux_follow: assert property (
		m_reg <= 4'h1 && aux_pin_one_oe_out |-> aux_pin_one_out == emitter_mux_hi_out)
		else $error("mux pin wrong");
	a_pin_two_off: assert property (
		m_reg == 4'h0 |-> !aux_pin_two_oe_out) else $error("pin two driven");
	a_clk_pin_input: assert property (
		m_reg == 4'h1 || m_reg == 4'h3 |-> !aux_pin_two_oe_out) else $error("clock pin driven");
	a_trig_pin_input: assert property (
		m_reg == 4'h2 || m_reg == 4'h3 |-> !aux_pin_one_oe_out) else $error("trigger pin driven");
	a_push_single: assert property (
		fifo_push_out |=> !fifo_push_out) else $error("push too long");
	a_tag_present: assert property (
		fifo_push_out |-> fifo_word_out[23:19] != 5'h00) else $error("tag missing");
	c_push_ext: cover property (fifo_push_out && m_reg == 4'h1);
	c_push_trig: cover property (fifo_push_out && m_reg == 4'h3);
	c_mux_high: cover property (emitter_mux_hi_out && aux_pin_one_out);
endmodule
bind osg_sync_gpio osg_sync_gpio_chk u_chk (.*);

// ---- tb/osg_far_end.sv ----
`timescale 1ns/10ps
module osg_far_end (
	input  wire run_in,
	input  wire trig_req_in,
	output reg  ext_clk_out,
	output reg  trig_out
);
	// Stands low while stopped
	initial begin
		ext_clk_out = 1'b0;
		trig_out = 1'b0;
		forever begin
			#15259;
			ext_clk_out = run_in ? ~ext_clk_out : 1'b0;
		end
	end
	always @(posedge ext_clk_out)
		trig_out <= trig_req_in;
endmodule

// ---- tb/tb_osg_sync_gpio.sv ----
`timescale 1ns/10ps
module tb_osg_sync_gpio;
	reg         clk_in, resetn_in, reg_we_in, slot_we_in, sample_period_in, run_clk, trig_req;
	reg  [7:0]  reg_addr_in, reg_wdata_in, v;
	reg  [2:0]  slot_addr_in;
	reg  [3:0]  slot_code_in;
	reg  [18:0] adc_value_in, r;
	wire [7:0]  reg_rdata_out;
	wire [23:0] fifo_word_out;
	wire        aux_pin_one_out, aux_pin_one_oe_out, aux_pin_two_out, aux_pin_two_oe_out;
	wire        emitter_mux_hi_out, fifo_push_out, busy_out, ext_clk, trig;
	wire        aux_pin_one_in = aux_pin_one_oe_out ? aux_pin_one_out : trig;
	wire        aux_pin_two_in = aux_pin_two_oe_out ? aux_pin_two_out : ext_clk;
	integer     err_total, tests_run, seed, n;
	reg  [23:0] exp_q[$];
	osg_sync_gpio u_dut (.*);
	osg_far_end u_far (.run_in(run_clk), .trig_req_in(trig_req), .ext_clk_out(ext_clk),
		.trig_out(trig));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task chk(input [23:0] s, input [23:0] e);
		tests_run = tests_run + 1;
		if (s !== e) begin
			err_total = err_total + 1;
			$display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk_in);
		reg_we_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_we_in <= 1'b0;
	endtask
	task rd(input [7:0] a);
		@(posedge clk_in);
		reg_addr_in <= a;
		repeat (2) @(posedge clk_in);
		v = reg_rdata_out;
	endtask
	task slots(input [23:0] c);
		for (n = 0; n < 6; n = n + 1) begin
			@(posedge clk_in);
			slot_we_in <= 1'b1;
			slot_addr_in <= n[2:0];
			slot_code_in <= c[4*n +: 4];
		end
		@(posedge clk_in);
		slot_we_in <= 1'b0;
		@(posedge clk_in);
	endtask
	// Trigger may lag by a whole timing clock period
	task idle;
		n = 0;
		while (busy_out !== 1'b1 && n < 8000) begin
			@(posedge clk_in);
			n = n + 1;
		end
		chk(busy_out, 1'b1);
		while (busy_out !== 1'b0 && n < 60000) begin
			@(posedge clk_in);
			n = n + 1;
		end
		chk(busy_out, 1'b0);
		$display("sequence test done at %0t", $time);
	endtask
	always @(posedge clk_in)
		if (fifo_push_out === 1'b1) begin
			if (exp_q.size() == 0)
				chk(24'h1, 24'h0);
			else
				chk(fifo_word_out, exp_q.pop_front());
		end
	task summarize;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#1000000;
		err_total = err_total + 1;
		summarize;
	end
	initial begin
		{resetn_in, reg_we_in, slot_we_in, sample_period_in, run_clk, trig_req} = 6'h00;
		{reg_addr_in, reg_wdata_in, slot_addr_in, slot_code_in, adc_value_in} = 42'h0;
		err_total = 0;
		tests_run = 0;
		seed = 32'hb2dc;
		repeat (8) @(posedge clk_in);
		resetn_in <= 1'b1;
		rd(8'h10);
		chk(v, 8'h00);
		rd(8'h33);
		chk(v, 8'h00);
		slots(24'h00009a);
		chk(aux_pin_one_oe_out, 1'b1);
		chk(aux_pin_two_oe_out, 1'b0);
		wr(8'h10, 8'h02);
		@(posedge clk_in);
		chk(aux_pin_two_oe_out, 1'b1);
		chk(aux_pin_two_out, 1'b0);
		wr(8'h10, 8'h01);
		rd(8'h10);
		chk(v, 8'h01);
		r = $random(seed);
		adc_value_in <= r;
		run_clk <= 1'b1;
		exp_q.push_back({5'h01, r});
		exp_q.push_back({5'h02, r});
		sample_period_in <= 1'b1;
		@(posedge clk_in);
		sample_period_in <= 1'b0;
		for (n = 0; n < 100 && emitter_mux_hi_out !== 1'b1; n = n + 1)
			@(posedge clk_in);
		chk(aux_pin_one_out, 1'b1);
		idle;
		slots(24'h000001);
		chk(aux_pin_one_oe_out, 1'b0);
		wr(8'h10, 8'h03);
		r = $random(seed);
		adc_value_in <= r;
		exp_q.push_back({5'h01, r});
		trig_req <= 1'b1;
		idle;
		trig_req <= 1'b0;
		wr(8'h10, 8'h04);
		r = $random(seed);
		adc_value_in <= r;
		exp_q.push_back({5'h01, r});
		sample_period_in <= 1'b1;
		@(posedge clk_in);
		sample_period_in <= 1'b0;
		for (n = 0; n < 10 && aux_pin_one_out !== 1'b1; n = n + 1)
			@(posedge clk_in);
		chk(aux_pin_one_out, 1'b1);
		chk(aux_pin_one_oe_out, 1'b1);
		idle;
		repeat (4000) @(posedge clk_in);
		chk(busy_out, 1'b0);
		chk(exp_q.size(), 24'h0);
		summarize;
	end
endmodule
